/* File: hw/tmz_pkg.sv */
// Package for the 8/16-bit timer/counter: register map, field positions, reset values.
// Assumes a 32-bit APB with one aligned word per register.
package tmz_pkg;
    // ****************************************************************
    // Register byte addresses
    // ****************************************************************
    localparam logic [7:0] ADDR_COUNT_LOW     = 8'h00;
    localparam logic [7:0] ADDR_COUNT_HIGH    = 8'h04;
    localparam logic [7:0] ADDR_CONTROL_A     = 8'h08;
    localparam logic [7:0] ADDR_CONTROL_B     = 8'h0C;
    localparam logic [7:0] ADDR_IRQ_STATUS    = 8'h10;
    localparam logic [7:0] ADDR_IRQ_MASK      = 8'h14;
    // ****************************************************************
    // Control register A fields
    // ****************************************************************
    localparam int CA_ENABLE_BIT  = 7;
    localparam int CA_OUT_BIT     = 5;
    localparam int CA_WIDTH_BIT   = 4;
    localparam int CA_POST_LSB    = 0;
    // ****************************************************************
    // Control register B fields
    // ****************************************************************
    localparam int CB_SOURCE_LSB  = 5;
    localparam int CB_ASYNC_BIT   = 4;
    localparam int CB_PRE_LSB     = 0;
    // ****************************************************************
    // Interrupt status bits
    // ****************************************************************
    localparam int IRQ_TIMER_BIT  = 0;
    localparam int IRQ_RAW_BIT    = 1;
    // ****************************************************************
    // Reset values and widths
    // ****************************************************************
    localparam logic [7:0]  RST_COUNT_LOW  = 8'h00;
    localparam logic [7:0]  RST_COUNT_HIGH = 8'hFF;
    localparam logic [7:0]  RST_CONTROL    = 8'h00;
    localparam logic [1:0]  RST_IRQ        = 2'b00;
    localparam int          PRESCALE_BITS  = 15;
    localparam logic [14:0] RST_PRESCALE   = 15'h0000;
    localparam logic [3:0]  RST_POSTSCALE  = 4'h0;
endpackage

/* File: hw/tmz_edge_sync.sv */
// Two-flop synchroniser with rising-edge detector for the timer input.
// Assumes the input pin is asynchronous to CLOCK.
module tmz_edge_sync (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // Pin and results
    input  wire logic pin_in,
    output logic      level_out,
    output logic      rise_out
);
    logic meta_q;
    logic meta_d;
    logic sync_q;
    logic sync_d;
    logic last_q;
    logic last_d;

    always_comb begin
        meta_d = pin_in;
        sync_d = meta_q;
        last_d = sync_q;
    end

    // First flop feeds only the second
    always_ff @(posedge clk) begin
        if (rst) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
            last_q <= 1'b0;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
            last_q <= last_d;
        end
    end

    assign level_out = sync_q;
    assign rise_out  = sync_q & ~last_q;
endmodule

/* File: hw/tmz_timer.sv */
// 8/16-bit timer/counter with prescaler, postscaler, APB registers and interrupt.
// Assumes one system clock; the external count input is a pin and is synchronised.
// Functional notes
// R1: One control bit picks 8-bit or 16-bit counting.
// R2: Counter advances on rising edges after a 15-bit prescaler set by prescale select.
// R3: 16-bit mode: reading low byte latches real high byte into holding register.
// R4: 16-bit mode: writing low byte loads real high byte from holding register.
// R5: 8-bit mode: low byte compared against period buffer every counter clock.
// R6: 8-bit match: pulse one prescaled period, clear low byte, reload period buffer.
// R7: 8-bit mode: both bytes direct; reset clears low, sets high to all ones.
// R8: Prescaler and postscaler clear on low write, control writes, reset.
// R9: Counter operation: prescale zero bypasses; each edge or prescaler output adds one.
// R10: Timer operation with prescale zero counts every instruction cycle.
// R11: Async select counts input edges directly; keeps counting while input runs. Code still takes the edges through the synchroniser.
// R12: Sync select synchronises input to instruction clock; rate bounded by it.
// R13: Prescale select offers sixteen power-of-two ratios, 1 to 32768.
// R14: Interrupt flag set every postscale-plus-one matches or rollovers.
// R15: Timer output toggles on each postscaled event, giving 50 percent duty.
// R16: 16-bit wrap from all ones makes a rollover event feeding the postscaler.
// R17: Counting and events only while module enable is set; else count holds.
module tmz_timer
    import tmz_pkg::*;
(
    // Clock and reset
    input  wire logic        CLOCK,
    input  wire logic        RESET,
    // APB slave
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [7:0]  PADDR,
    input  wire logic [31:0] PWDATA,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    // Count inputs
    input  wire logic        EXT_CLOCK_IN,
    input  wire logic        SLEEP,
    // Outputs
    output logic             MATCH_PULSE,
    output logic             TIMER_OUT,
    output logic             IRQ
);
    import tmz_pkg::*;

    // ****************************************************************
    // Functions
    // ****************************************************************
    // Tap mask for a power-of-two prescale ratio
    function automatic logic [14:0] pre_mask(input logic [3:0] sel);
        logic [15:0] one_hot;
        one_hot = (16'h0001 << sel) - 16'h0001;
        // Select 15 gives all fifteen bits set, the slowest ratio
        pre_mask = one_hot[14:0];
    endfunction

    function automatic logic [7:0] byte_of(input logic [31:0] word);
        byte_of = word[7:0];
    endfunction

    // ****************************************************************
    // State
    // ****************************************************************
    logic [7:0]  low_q,  low_d;
    logic [7:0]  real_high_q, real_high_d;
    logic [7:0]  hold_q, hold_d;
    logic [7:0]  period_q, period_d;
    logic [7:0]  ctl_a_q, ctl_a_d;
    logic [7:0]  ctl_b_q, ctl_b_d;
    logic [14:0] pre_q, pre_d;
    logic [3:0]  post_q, post_d;
    logic        out_q, out_d;
    logic        match_q, match_d;
    logic [1:0]  status_q, status_d;
    logic [1:0]  mask_q, mask_d;

    logic ext_level;
    logic ext_rise;
    logic ext_raw_q;
    logic ext_raw_d;

    tmz_edge_sync u_sync (
        .clk       (CLOCK),
        .rst       (RESET),
        .pin_in    (EXT_CLOCK_IN),
        .level_out (ext_level),
        .rise_out  (ext_rise)
    );

    // ****************************************************************
    // Decode
    // ****************************************************************
    logic access;
    logic wr;
    logic rd;
    logic enable;
    logic wide;
    logic async_sel;
    logic [3:0] pre_sel;
    logic [3:0] post_sel;
    logic [2:0] src_sel;
    logic tick_src;
    logic count_tick;
    logic event_hit;
    logic post_fire;
    logic async_rise;

    assign access    = PSEL & PENABLE;
    assign wr        = access & PWRITE;
    assign rd        = access & ~PWRITE;
    assign enable    = ctl_a_q[CA_ENABLE_BIT];
    assign wide      = ctl_a_q[CA_WIDTH_BIT];                          // R1
    assign async_sel = ctl_b_q[CB_ASYNC_BIT];
    assign pre_sel   = ctl_b_q[CB_PRE_LSB +: 4];
    assign post_sel  = ctl_a_q[CA_POST_LSB +: 4];
    assign src_sel   = ctl_b_q[CB_SOURCE_LSB +: 3];

    // Async path still uses the synchronised level and the same edge pairing; only the sleep gating differs
    assign async_rise = ext_level & ~ext_raw_q;                         // R11

    always_comb begin
        ext_raw_d = ext_level;
        // Source zero counts pin edges, any other selects the instruction clock
        if (src_sel == 3'b000) begin
            tick_src = async_sel ? async_rise : ext_rise;               // R9 R12
        end else begin
            tick_src = 1'b1;                                            // R10
        end
    end

    // Sync mode halts in sleep; async keeps counting
    logic run;
    assign run = enable & (async_sel | ~SLEEP);                         // R11 R17

    // Prescaler: bypass at zero, else carry out when masked bits all set
    assign count_tick = run & tick_src & ((pre_sel == 4'h0) |
                        ((pre_q & pre_mask(pre_sel)) == pre_mask(pre_sel))); // R2 R13

    logic [15:0] wide_next;
    assign wide_next = {real_high_q, low_q} + 16'h0001;

    always_comb begin
        if (wide) begin
            event_hit = count_tick & ({real_high_q, low_q} == 16'hFFFF); // R16
        end else begin
            event_hit = count_tick & (low_q == period_q);               // R5
        end
    end

    assign post_fire = event_hit & (post_q == post_sel);                // R14

    // ****************************************************************
    // Counter and scalers
    // ****************************************************************
    always_comb begin
        low_d       = low_q;
        real_high_d = real_high_q;
        hold_d      = hold_q;
        period_d    = period_q;
        ctl_a_d     = ctl_a_q;
        ctl_b_d     = ctl_b_q;
        pre_d       = pre_q;
        post_d      = post_q;
        out_d       = out_q;
        match_d     = match_q;
        if (run & tick_src) begin
            pre_d = pre_q + 15'h0001;
        end
        if (count_tick) begin
            match_d = 1'b0;
            if (wide) begin
                low_d       = wide_next[7:0];
                real_high_d = wide_next[15:8];
            end else if (event_hit) begin
                low_d    = RST_COUNT_LOW;                               // R6
                period_d = hold_q;                                      // R6
                match_d  = 1'b1;                                        // R6
            end else begin
                low_d = low_q + 8'h01;                                  // R9
            end
            if (event_hit) begin
                match_d = 1'b1;                                         // R16
                post_d  = post_fire ? RST_POSTSCALE : post_q + 4'h1;
            end
            if (post_fire) begin
                out_d = ~out_q;                                         // R15
            end
        end
        if (!enable) begin
            match_d = 1'b0;                                             // R17
        end
        // Holding byte freezes the high half so a split 16-bit read cannot tear
        if (rd && PADDR == ADDR_COUNT_LOW && wide) begin
            hold_d = real_high_q;                                       // R3
        end
        if (wr) begin
            case (PADDR)
                ADDR_COUNT_LOW: begin
                    low_d  = byte_of(PWDATA);
                    if (wide) begin
                        real_high_d = hold_q;                           // R4
                    end
                    pre_d  = RST_PRESCALE;                              // R8
                    post_d = RST_POSTSCALE;                             // R8
                end
                ADDR_COUNT_HIGH: begin
                    hold_d = byte_of(PWDATA);                           // R7
                end
                ADDR_CONTROL_A: begin
                    ctl_a_d = byte_of(PWDATA) & 8'b1001_1111;
                    pre_d   = RST_PRESCALE;                             // R8
                    post_d  = RST_POSTSCALE;                            // R8
                end
                ADDR_CONTROL_B: begin
                    ctl_b_d = byte_of(PWDATA);
                    pre_d   = RST_PRESCALE;                             // R8
                    post_d  = RST_POSTSCALE;                            // R8
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            low_q       <= RST_COUNT_LOW;                               // R7
            real_high_q <= RST_COUNT_LOW;
            hold_q      <= RST_COUNT_HIGH;                              // R7
            period_q    <= RST_COUNT_HIGH;
            ctl_a_q     <= RST_CONTROL;
            ctl_b_q     <= RST_CONTROL;
            pre_q       <= RST_PRESCALE;                                // R8
            post_q      <= RST_POSTSCALE;                               // R8
            out_q       <= 1'b0;
            match_q     <= 1'b0;
            ext_raw_q   <= 1'b0;
        end else begin
            low_q       <= low_d;
            real_high_q <= real_high_d;
            hold_q      <= hold_d;
            period_q    <= period_d;
            ctl_a_q     <= ctl_a_d;
            ctl_b_q     <= ctl_b_d;
            pre_q       <= pre_d;
            post_q      <= post_d;
            out_q       <= out_d;
            match_q     <= match_d;
            ext_raw_q   <= ext_raw_d;
        end
    end

    // ****************************************************************
    // Interrupt and read data
    // ****************************************************************
    always_comb begin
        status_d = status_q;
        mask_d   = mask_q;
        if (rd && PADDR == ADDR_IRQ_STATUS) begin
            status_d = RST_IRQ;
        end
        if (wr && PADDR == ADDR_IRQ_MASK) begin
            mask_d = PWDATA[1:0];
        end
        // Set wins over the read clear
        if (post_fire) begin
            status_d[IRQ_TIMER_BIT] = 1'b1;                             // R14
        end
        if (event_hit) begin
            status_d[IRQ_RAW_BIT] = 1'b1;
        end
    end

    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            status_q <= RST_IRQ;
            mask_q   <= RST_IRQ;
        end else begin
            status_q <= status_d;
            mask_q   <= mask_d;
        end
    end

    // Zero-wait slave: read data is combinational in the access phase
    always_comb begin
        case (PADDR)
            ADDR_COUNT_LOW:  PRDATA = {24'h00_0000, low_q};
            ADDR_COUNT_HIGH: PRDATA = {24'h00_0000, hold_q};
            ADDR_CONTROL_A:  PRDATA = {24'h00_0000, ctl_a_q | ({7'h00, out_q} << CA_OUT_BIT)};
            ADDR_CONTROL_B:  PRDATA = {24'h00_0000, ctl_b_q};
            ADDR_IRQ_STATUS: PRDATA = {30'h0000_0000, status_q};
            ADDR_IRQ_MASK:   PRDATA = {30'h0000_0000, mask_q};
            default:         PRDATA = 32'h0000_0000;
        endcase
    end

    logic mapped;
    assign mapped  = (PADDR <= ADDR_IRQ_MASK) && (PADDR[1:0] == 2'b00);
    assign PREADY  = 1'b1;
    assign PSLVERR = access & ~mapped;
    assign MATCH_PULSE = match_q;
    assign TIMER_OUT   = out_q;
    assign IRQ         = |(status_q & mask_q);
endmodule

/* File: testbench/tmz_timer_checker.sv */
// Port-level checker for the timer: bus answers, register readback, interrupt gating.
// Assumes it is bound to tmz_timer and sees only that module's ports.
module tmz_timer_checker
    import tmz_pkg::*;
(
    // Clock and reset
    input wire logic        CLOCK,
    input wire logic        RESET,
    // APB slave
    input wire logic        PSEL,
    input wire logic        PENABLE,
    input wire logic        PWRITE,
    input wire logic [7:0]  PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [31:0] PRDATA,
    input wire logic        PREADY,
    input wire logic        PSLVERR,
    // Count inputs
    input wire logic        EXT_CLOCK_IN,
    input wire logic        SLEEP,
    // Outputs
    input wire logic        MATCH_PULSE,
    input wire logic        TIMER_OUT,
    input wire logic        IRQ
);
    // ****************************************************************
    // Shadow copies of the writable control state
    // ****************************************************************
    logic       wr;
    logic       rd;
    logic       bad;
    logic [7:0] ca_d, ca_q, cb_d, cb_q;
    logic [1:0] mask_d, mask_q;
    logic [2:0] off_d, off_q;
    assign wr  = PSEL && PENABLE && PWRITE;
    assign rd  = PSEL && PENABLE && !PWRITE;
    assign bad = PADDR > ADDR_IRQ_MASK || PADDR[1:0] != 2'b00;
    always_comb begin
        ca_d   = (wr && PADDR == ADDR_CONTROL_A) ? (PWDATA[7:0] & 8'h9F) : ca_q;
        cb_d   = (wr && PADDR == ADDR_CONTROL_B) ? PWDATA[7:0] : cb_q;
        mask_d = (wr && PADDR == ADDR_IRQ_MASK) ? PWDATA[1:0] : mask_q;
        off_d  = {off_q[1:0], ~ca_q[CA_ENABLE_BIT]};
    end
    // Enable history: three quiet cycles cover any pipeline of a pending tick
    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            ca_q   <= 8'h00;
            cb_q   <= 8'h00;
            mask_q <= 2'b00;
            off_q  <= 3'b111;
        end else begin
            ca_q   <= ca_d;
            cb_q   <= cb_d;
            mask_q <= mask_d;
            off_q  <= off_d;
        end
    end
    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking @(posedge CLOCK); endclocking
    default disable iff (RESET);
    a_ready_zero_wait: assert property (PSEL && PENABLE |-> PREADY) else $error("bus answer not ready");
    a_reset_quiet: assert property ($fell(RESET) |-> !MATCH_PULSE && !TIMER_OUT && !IRQ)
        else $error("outputs active after reset");
    a_refuse_unmapped: assert property (PSEL && PENABLE && bad |-> PSLVERR && (PWRITE || PRDATA == 32'h0000_0000))
        else $error("unmapped access not refused");
    a_accept_mapped: assert property (PSEL && PENABLE && !bad |-> !PSLVERR) else $error("mapped access refused");
    a_upper_zero: assert property (rd |-> PRDATA[31:8] == 24'h00_0000) else $error("upper read bits set");
    a_ctrl_a_back: assert property (
        rd && PADDR == ADDR_CONTROL_A |-> PRDATA[7:0] == (ca_q | {2'b00, TIMER_OUT, 5'h00}))
        else $error("control a readback wrong");
    a_ctrl_b_back: assert property (rd && PADDR == ADDR_CONTROL_B |-> PRDATA[7:0] == cb_q)
        else $error("control b readback wrong");
    a_mask_back: assert property (rd && PADDR == ADDR_IRQ_MASK |-> PRDATA == {30'h0000_0000, mask_q})
        else $error("mask readback wrong");
    a_irq_gated: assert property (mask_q == 2'b00 |-> !IRQ) else $error("interrupt while masked");
    a_hold_disabled: assert property (
        off_q == 3'b111 && !ca_q[CA_ENABLE_BIT] |-> $stable(TIMER_OUT) && !$rose(MATCH_PULSE))
        else $error("activity while disabled");
endmodule

bind tmz_timer tmz_timer_checker chk (.CLOCK(CLOCK), .RESET(RESET), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .EXT_CLOCK_IN(EXT_CLOCK_IN), .SLEEP(SLEEP), .MATCH_PULSE(MATCH_PULSE), .TIMER_OUT(TIMER_OUT), .IRQ(IRQ));

/* File: testbench/tmz_timer_tb.sv */
// Self-checking bench for tmz_timer: APB tasks and one task per scenario.
// Assumes one 100 MHz clock and the register map of tmz_pkg.
module tmz_timer_tb import tmz_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, ext = 0, slp = 0, err;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic        pready, pslverr, mpulse, tout, irq;
    int          n_errors = 0, n_tests = 0;
    tmz_timer uut (.CLOCK(clk), .RESET(rst), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr), .PADDR(paddr),
        .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .EXT_CLOCK_IN(ext),
        .SLEEP(slp), .MATCH_PULSE(mpulse), .TIMER_OUT(tout), .IRQ(irq));
    initial forever #5 clk = ~clk;
    // ****************************************************************
    // Shared tasks
    // ****************************************************************
    task automatic complete_run();
        $display("TB: %0d checks, %0d errors", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [31:0] r);
        int i;
        @(posedge clk);
        psel   <= 1'b1;
        paddr  <= a;
        pwr    <= w;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        i = 0;
        do begin
            @(posedge clk);
            i++;
        end while (pready !== 1'b1 && i < 20);
        r    = prdata;
        err  = pslverr;
        psel <= 1'b0;
        pen  <= 1'b0;
        if (i >= 20) begin
            n_errors++;
            complete_run();
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] r;
        apb(a, 1'b1, {24'h00_0000, d}, r);
    endtask
    // Cycles until the watched output changes level; a stuck output ends the run
    // Selector: 0 watches the match pulse, 1 the timer output
    task automatic gap(input bit on_out, output int n);
        logic v;
        v = on_out ? tout : mpulse;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while ((on_out ? tout : mpulse) === v && n < 2000);
        if (n >= 2000) begin
            n_errors++;
            complete_run();
        end
    endtask
    task automatic rise(input bit on_out, output int n);
        int k;
        n = 0;
        do begin
            gap(on_out, k);
            n += k;
        end while ((on_out ? tout : mpulse) !== 1'b1);
    endtask
    task automatic pulses(input int n);
        repeat (n) begin
            repeat (3) @(posedge clk);
            ext <= 1'b1;
            repeat (3) @(posedge clk);
            ext <= 1'b0;
        end
        repeat (4) @(posedge clk);
    endtask
    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic t_reset();
        logic [7:0]  ad [6] = '{ADDR_COUNT_LOW, ADDR_COUNT_HIGH, ADDR_CONTROL_A, ADDR_CONTROL_B,
                                ADDR_IRQ_STATUS, 8'h18};
        logic [31:0] r;
        for (int k = 0; k < 6; k++) begin
            apb(ad[k], 1'b0, 32'h0000_0000, r);
            chk(r, (k == 1) ? 32'h0000_00FF : 32'h0000_0000);
            chk({31'h0000_0000, err}, {31'h0000_0000, k == 5});
        end
    endtask
    task automatic t_eight();
        logic [31:0] r, q;
        int          h, l, n;
        wr(ADDR_COUNT_HIGH, 8'h03);
        wr(ADDR_COUNT_LOW, 8'hFE);
        wr(ADDR_CONTROL_A, 8'h80);
        // Period buffer holds all ones until the first match reloads it
        for (int s = 0; s < 4; s++) begin
            wr(ADDR_CONTROL_B, 8'h20 | s[7:0]);
            rise(1'b0, n);
            gap(1'b0, h);
            gap(1'b0, l);
            chk(h, 1 << s);
            chk(h + l, 4 << s);
        end
        wr(ADDR_CONTROL_B, 8'h20);
        wr(ADDR_CONTROL_A, 8'h82);
        wr(ADDR_IRQ_MASK, 8'h01);
        gap(1'b1, n);
        gap(1'b1, n);
        chk(n, 12);
        repeat (2) @(posedge clk);
        chk(irq, 1'b1);
        apb(ADDR_IRQ_STATUS, 1'b0, 32'h0000_0000, r);
        chk(r[0], 1'b1);
        // The read clear lands at the access edge; IRQ is combinational and drops with it
        @(posedge clk);
        chk(irq, 1'b0);
        wr(ADDR_IRQ_MASK, 8'h00);
        wr(ADDR_CONTROL_A, 8'h00);
        apb(ADDR_COUNT_LOW, 1'b0, 32'h0000_0000, r);
        repeat (20) @(posedge clk);
        apb(ADDR_COUNT_LOW, 1'b0, 32'h0000_0000, q);
        chk(q, r);
    endtask
    task automatic t_sixteen();
        logic [31:0] r;
        int          n;
        wr(ADDR_CONTROL_A, 8'h10);
        wr(ADDR_COUNT_HIGH, 8'h12);
        wr(ADDR_COUNT_LOW, 8'h34);
        apb(ADDR_COUNT_LOW, 1'b0, 32'h0000_0000, r);
        chk(r, 32'h0000_0034);
        apb(ADDR_COUNT_HIGH, 1'b0, 32'h0000_0000, r);
        chk(r, 32'h0000_0012);
        wr(ADDR_COUNT_HIGH, 8'hFF);
        wr(ADDR_COUNT_LOW, 8'hFD);
        wr(ADDR_CONTROL_A, 8'h90);
        rise(1'b0, n);
        chk(n < 8, 1'b1);
        apb(ADDR_COUNT_LOW, 1'b0, 32'h0000_0000, r);
        chk(r < 32'h0000_0010, 1'b1);
        apb(ADDR_COUNT_HIGH, 1'b0, 32'h0000_0000, r);
        chk(r, 32'h0000_0000);
    endtask
    task automatic t_count();
        logic [31:0] r;
        wr(ADDR_CONTROL_B, 8'h00);
        wr(ADDR_COUNT_HIGH, 8'h00);
        wr(ADDR_COUNT_LOW, 8'h00);
        pulses(5);
        apb(ADDR_COUNT_LOW, 1'b0, 32'h0000_0000, r);
        chk(r, 32'h0000_0005);
        slp <= 1'b1;
        pulses(3);
        apb(ADDR_COUNT_LOW, 1'b0, 32'h0000_0000, r);
        chk(r, 32'h0000_0005);
        wr(ADDR_CONTROL_B, 8'h10);
        pulses(3);
        apb(ADDR_COUNT_LOW, 1'b0, 32'h0000_0000, r);
        chk(r, 32'h0000_0008);
        slp <= 1'b0;
    endtask
    initial begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        $display("reset test done");
        t_eight();
        $display("eight-bit test done");
        t_sixteen();
        $display("sixteen-bit test done");
        t_count();
        $display("counter test done");
        complete_run();
    end
endmodule
